// ### rtl/dbm_mux.sv
// Contract
// - power clear empties break, select, grant state
// - any request gives one inverted break request
// - first timing pulse selects a requesting channel while the log has room
// - lower channel number wins, others stay clear
// - address accepted grants and pulses selected channel
// - active level needs break and own grant
// - overflow pulse goes to granted channel only
// - data select follows grant flip-flop
// - address select follows select flip-flop
// - selected 12-bit address passes to processor
// - selected cycle type passes to processor
// - selected extended address bits pass to processor
// - granted 12-bit data passes to processor
// - granted increment inhibit passes to processor
// - selected direction passes to processor
// - seven channels, zero to six
`timescale 1ns/10ps
`include "dbm_defs.svh"

module dbm_mux (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // processor control
  input wire logic power_clear_in,
  input wire logic first_timing_pulse_in,
  input wire logic address_accepted_pulse_in,
  input wire logic word_count_overflow_in,
  input wire logic break_done_in,
  output logic break_request_n_out,
  // processor data path
  output logic [`DBM_AW-1:0] memory_address_bits_out,
  output logic [`DBM_XW-1:0] extended_address_bits_out,
  output logic cycle_type_select_out,
  output logic data_in_dir_out,
  output logic [`DBM_DW-1:0] transfer_data_bits_out,
  output logic current_address_increment_inhibit_out,
  // peripheral inputs, one lane per channel
  input wire logic [`DBM_NCH-1:0] break_request_line_in,
  input wire logic [`DBM_NCH-1:0][`DBM_AW-1:0] memory_address_bits_dev_in,
  input wire logic [`DBM_NCH-1:0][`DBM_XW-1:0] extended_address_bits_dev_in,
  input wire logic [`DBM_NCH-1:0] cycle_type_select_dev_in,
  input wire logic [`DBM_NCH-1:0] data_out_dir_dev_in,
  input wire logic [`DBM_NCH-1:0][`DBM_DW-1:0] transfer_data_bits_dev_in,
  input wire logic [`DBM_NCH-1:0] current_address_increment_inhibit_dev_in,
  // peripheral outputs
  output logic [`DBM_NCH-1:0] address_accepted_pulse_out,
  output logic [`DBM_NCH-1:0] word_count_overflow_dev_out,
  output logic [`DBM_NCH-1:0] channel_active_level_out,
  output logic [`DBM_NCH-1:0] data_bits_select_out,
  output logic [`DBM_NCH-1:0] address_lines_select_out,
  // break log stream
  output logic log_valid_out,
  input wire logic log_ready_in,
  output logic [`DBM_LOG_W-1:0] log_data_out
);

  dbm_pkg::dbm_state_s st_q;
  dbm_pkg::dbm_state_s st_d;

  logic [`DBM_NCH-1:0] winner;
  logic arb_go;
  logic log_push;
  logic log_room;
  logic [`DBM_CW-1:0] grant_idx;
  logic [`DBM_CW-1:0] sel_idx;
  logic [`DBM_LOG_W-1:0] log_rec;

  // per-channel gated lanes combined by a running or
  logic [`DBM_NCH:0][`DBM_AW-1:0] addr_or;
  logic [`DBM_NCH:0][`DBM_XW-1:0] ext_or;
  logic [`DBM_NCH:0][`DBM_DW-1:0] data_or;
  logic [`DBM_NCH:0] cyc_or;
  logic [`DBM_NCH:0] dir_or;
  logic [`DBM_NCH:0] inh_or;

  function automatic logic [`DBM_CW-1:0] chan_code(input logic [`DBM_NCH-1:0] onehot);
    logic [`DBM_CW-1:0] code;
    code = '0;
    for (int i = 0; i < `DBM_NCH; i++) begin
      if (onehot[i]) begin
        code = `DBM_CW'(i);
      end
    end
    return code;
  endfunction

  assign break_request_n_out = !(|break_request_line_in);

  // isolating the lowest set bit gives fixed priority to channel zero
  assign winner = break_request_line_in & (~break_request_line_in + 7'h01);
  // arbitration waits for log room, so a finished break can always be logged
  assign arb_go = (st_q.st == dbm_pkg::dbm_st_idle) && first_timing_pulse_in
    && (|break_request_line_in) && log_room;
  assign log_push = (st_q.st == dbm_pkg::dbm_st_grant) && break_done_in
    && !power_clear_in;
  assign grant_idx = chan_code(st_q.grant);
  assign sel_idx = chan_code(st_q.sel);
  assign log_rec = {grant_idx, st_q.maddr, st_q.mext, st_q.data};

  assign addr_or[0] = '0;
  assign ext_or[0] = '0;
  assign data_or[0] = '0;
  assign cyc_or[0] = 1'b0;
  assign dir_or[0] = 1'b0;
  assign inh_or[0] = 1'b0;

  for (genvar g = 0; g < `DBM_NCH; g++) begin : g_chan
    assign address_lines_select_out[g] = st_q.sel[g];
    assign data_bits_select_out[g] = st_q.grant[g];
    assign address_accepted_pulse_out[g] = address_accepted_pulse_in
      && (st_q.st == dbm_pkg::dbm_st_sel) && st_q.sel[g];
    assign word_count_overflow_dev_out[g] = word_count_overflow_in && st_q.grant[g];
    assign channel_active_level_out[g] = st_q.brk_act && st_q.grant[g];
    assign addr_or[g+1] = addr_or[g]
      | (memory_address_bits_dev_in[g] & {`DBM_AW{st_q.sel[g]}});
    assign ext_or[g+1] = ext_or[g]
      | (extended_address_bits_dev_in[g] & {`DBM_XW{st_q.sel[g]}});
    assign cyc_or[g+1] = cyc_or[g] | (cycle_type_select_dev_in[g] & st_q.sel[g]);
    assign dir_or[g+1] = dir_or[g] | (data_out_dir_dev_in[g] & st_q.sel[g]);
    assign data_or[g+1] = data_or[g]
      | (transfer_data_bits_dev_in[g] & {`DBM_DW{st_q.grant[g]}});
    assign inh_or[g+1] = inh_or[g]
      | (current_address_increment_inhibit_dev_in[g] & st_q.grant[g]);
  end

  always_comb begin
    st_d = st_q;
    // data lanes are re-registered every cycle: address, extended, cycle and direction from select, data and inhibit from grant
    st_d.maddr = addr_or[`DBM_NCH];
    st_d.mext = ext_or[`DBM_NCH];
    st_d.cyc = cyc_or[`DBM_NCH];
    st_d.dir = dir_or[`DBM_NCH];
    st_d.data = data_or[`DBM_NCH];
    st_d.inh = inh_or[`DBM_NCH];
    case (st_q.st)
      dbm_pkg::dbm_st_idle: begin
        if (arb_go) begin
          st_d.sel = winner;
          st_d.st = dbm_pkg::dbm_st_sel;
        end
      end
      dbm_pkg::dbm_st_sel: begin
        // a peripheral must keep its request up until this pulse
        if (address_accepted_pulse_in) begin
          st_d.grant = st_q.sel;
          st_d.brk_act = 1'b1;
          st_d.st = dbm_pkg::dbm_st_grant;
        end
      end
      dbm_pkg::dbm_st_grant: begin
        if (break_done_in) begin
          st_d.sel = `DBM_CH_RST;
          st_d.grant = `DBM_CH_RST;
          st_d.brk_act = 1'b0;
          st_d.st = dbm_pkg::dbm_st_idle;
        end
      end
      default: begin
        st_d.st = dbm_pkg::dbm_st_idle;
        st_d.sel = `DBM_CH_RST;
        st_d.grant = `DBM_CH_RST;
        st_d.brk_act = 1'b0;
      end
    endcase
    // power clear needs no channel addressing and beats everything else
    if (power_clear_in) begin
      st_d.st = dbm_pkg::dbm_st_idle;
      st_d.sel = `DBM_CH_RST;
      st_d.grant = `DBM_CH_RST;
      st_d.brk_act = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_q.st <= dbm_pkg::dbm_st_idle;
      st_q.sel <= `DBM_CH_RST;
      st_q.grant <= `DBM_CH_RST;
      st_q.brk_act <= 1'b0;
      st_q.maddr <= `DBM_ADDR_RST;
      st_q.mext <= `DBM_EXT_RST;
      st_q.cyc <= 1'b0;
      st_q.dir <= 1'b0;
      st_q.data <= `DBM_DATA_RST;
      st_q.inh <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign memory_address_bits_out = st_q.maddr;
  assign extended_address_bits_out = st_q.mext;
  assign cycle_type_select_out = st_q.cyc;
  assign data_in_dir_out = st_q.dir;
  assign transfer_data_bits_out = st_q.data;
  assign current_address_increment_inhibit_out = st_q.inh;

  dbm_log_fifo #(.W(`DBM_LOG_W), .D(`DBM_LOG_DEPTH), .PW(`DBM_LOG_PW)) u_log (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(log_push),
    .in_ready_out(log_room),
    .in_data_in(log_rec),
    .out_valid_out(log_valid_out),
    .out_ready_in(log_ready_in),
    .out_data_out(log_data_out)
  );

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_power_clear;
    power_clear_in |=> (st_q.st == dbm_pkg::dbm_st_idle) && (st_q.sel == 7'h00)
      && (st_q.grant == 7'h00) && !st_q.brk_act;
  endproperty
  a_power_clear: assert property (p_power_clear)
    else $error("power clear left break state set");

  property p_merged_request;
    $rose(|break_request_line_in) |-> !break_request_n_out;
  endproperty
  a_merged_request: assert property (p_merged_request)
    else $error("break request not forwarded");

  property p_select_winner;
    (arb_go && !power_clear_in) |=>
      (st_q.sel == $past(winner)) && ((st_q.sel & ~$past(break_request_line_in)) == 7'h00);
  endproperty
  a_select_winner: assert property (p_select_winner)
    else $error("select did not latch the requesting winner");

  property p_one_select;
    $onehot0(st_q.sel) && $onehot0(st_q.grant);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one channel selected");

  property p_grant_follows_accept;
    (address_accepted_pulse_in && (st_q.st == dbm_pkg::dbm_st_sel) && !power_clear_in)
      |-> (address_accepted_pulse_out == st_q.sel) ##1 (st_q.grant == $past(st_q.sel));
  endproperty
  a_grant_follows_accept: assert property (p_grant_follows_accept)
    else $error("accept pulse did not grant the selected channel");

  property p_active_level;
    (channel_active_level_out != 7'h00) |-> st_q.brk_act
      && (channel_active_level_out == st_q.grant);
  endproperty
  a_active_level: assert property (p_active_level)
    else $error("active level without break or grant");

  property p_overflow_route;
    (word_count_overflow_dev_out != 7'h00) |-> word_count_overflow_in
      && (word_count_overflow_dev_out == st_q.grant);
  endproperty
  a_overflow_route: assert property (p_overflow_route)
    else $error("overflow pulse reached a channel without grant");

  property p_address_pass;
    ((st_q.sel != 7'h00) && !power_clear_in && !break_done_in) |=>
      memory_address_bits_out == $past(memory_address_bits_dev_in[sel_idx]);
  endproperty
  a_address_pass: assert property (p_address_pass)
    else $error("selected address not passed through");

  property p_ext_pass;
    (st_q.sel != 7'h00) |=>
      extended_address_bits_out == $past(extended_address_bits_dev_in[sel_idx]);
  endproperty
  a_ext_pass: assert property (p_ext_pass)
    else $error("selected extended address not passed through");

  property p_cycle_pass;
    (st_q.sel != 7'h00) |=>
      cycle_type_select_out == $past(cycle_type_select_dev_in[sel_idx]);
  endproperty
  a_cycle_pass: assert property (p_cycle_pass)
    else $error("selected cycle type not passed through");

  property p_dir_pass;
    (st_q.sel != 7'h00) |=>
      data_in_dir_out == $past(data_out_dir_dev_in[sel_idx]);
  endproperty
  a_dir_pass: assert property (p_dir_pass)
    else $error("selected direction not passed through");

  property p_inhibit_pass;
    (st_q.grant != 7'h00) |=> current_address_increment_inhibit_out
      == $past(current_address_increment_inhibit_dev_in[grant_idx]);
  endproperty
  a_inhibit_pass: assert property (p_inhibit_pass)
    else $error("granted increment inhibit not passed through");

  property p_data_pass;
    ((st_q.grant != 7'h00) && !power_clear_in && !break_done_in) |=>
      transfer_data_bits_out == $past(transfer_data_bits_dev_in[grant_idx]);
  endproperty
  a_data_pass: assert property (p_data_pass)
    else $error("granted data not passed through");

  property p_release;
    ((st_q.st == dbm_pkg::dbm_st_grant) && break_done_in) |=>
      (st_q.sel == 7'h00) && (st_q.grant == 7'h00) ##1 (memory_address_bits_out == 12'h000);
  endproperty
  a_release: assert property (p_release)
    else $error("break completion did not release the channel");

endmodule

// ### rtl/dbm_defs.svh
`ifndef DBM_DEFS_SVH
`define DBM_DEFS_SVH

// channel count and field widths
`define DBM_NCH 7
`define DBM_CW 3
`define DBM_AW 12
`define DBM_XW 3
`define DBM_DW 12

// break log record: channel code, address, extended address, data
`define DBM_LOG_W 30
`define DBM_LOG_DEPTH 32
`define DBM_LOG_PW 5

// one-hot state codes
`define DBM_ST_IDLE 3'b001
`define DBM_ST_SEL 3'b010
`define DBM_ST_GRANT 3'b100

// reset values
`define DBM_CH_RST 7'h00
`define DBM_ADDR_RST 12'h000
`define DBM_EXT_RST 3'h0
`define DBM_DATA_RST 12'h000

`endif

// ### rtl/dbm_pkg.sv
`include "dbm_defs.svh"

package dbm_pkg;

  typedef enum logic [2:0] {
    dbm_st_idle = `DBM_ST_IDLE,
    dbm_st_sel = `DBM_ST_SEL,
    dbm_st_grant = `DBM_ST_GRANT
  } dbm_state_e;

  typedef struct packed {
    dbm_state_e st;
    logic [`DBM_NCH-1:0] sel;
    logic [`DBM_NCH-1:0] grant;
    logic brk_act;
    logic [`DBM_AW-1:0] maddr;
    logic [`DBM_XW-1:0] mext;
    logic cyc;
    logic dir;
    logic [`DBM_DW-1:0] data;
    logic inh;
  } dbm_state_s;

endpackage

// ### rtl/dbm_log_mem.sv
`timescale 1ns/10ps

module dbm_log_mem #(
  parameter int W = 30,
  parameter int D = 32,
  parameter int PW = 5
) (
  // clock
  input wire logic core_clk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [PW-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  // read port, data registered
  input wire logic [PW-1:0] rd_addr_in,
  output logic [W-1:0] rd_data_out
);

  logic [W-1:0] mem_q [D];

  // read before write: a same-address write shows up one cycle later
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

// ### rtl/dbm_log_fifo.sv
`timescale 1ns/10ps

module dbm_log_fifo #(
  parameter int W = 30,
  parameter int D = 32,
  parameter int PW = 5
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic stale;
  } dbm_fifo_s;

  localparam logic [PW:0] FULL_CNT = (PW+1)'(D);

  dbm_fifo_s st_q;
  dbm_fifo_s st_d;
  logic push;
  logic pop;

  assign in_ready_out = (st_q.cnt != FULL_CNT);
  // stale marks a read that raced a write to the same slot
  assign out_valid_out = (st_q.cnt != '0) && !st_q.stale;

  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    st_d = st_q;
    st_d.wp = st_q.wp + PW'(push);
    st_d.rp = st_q.rp + PW'(pop);
    st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    st_d.stale = push && (st_q.wp == st_d.rp);
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  dbm_log_mem #(.W(W), .D(D), .PW(PW)) u_mem (
    .core_clk_in(core_clk_in),
    .wr_en_in(push),
    .wr_addr_in(st_q.wp),
    .wr_data_in(in_data_in),
    .rd_addr_in(st_d.rp),
    .rd_data_out(out_data_out)
  );

endmodule

// ### dv/dbm_periph_model.sv
`timescale 1ns/10ps
`include "dbm_defs.svh"

module dbm_periph_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // bench wish to start a request, one bit per channel
  input wire logic [`DBM_NCH-1:0] want_in,
  input wire logic [`DBM_NCH-1:0] accept_in,
  // lines toward the multiplexer
  output logic [`DBM_NCH-1:0] req_out,
  output logic [`DBM_NCH-1:0][`DBM_AW-1:0] addr_out,
  output logic [`DBM_NCH-1:0][`DBM_XW-1:0] ext_out,
  output logic [`DBM_NCH-1:0] cyc_out,
  output logic [`DBM_NCH-1:0] dir_out,
  output logic [`DBM_NCH-1:0][`DBM_DW-1:0] data_out,
  output logic [`DBM_NCH-1:0] inh_out
);
  logic [`DBM_NCH-1:0] req_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      req_q <= `DBM_CH_RST;
    end else begin
      req_q <= (req_q | want_in) & ~accept_in;
    end
  end

  assign req_out = req_q;

  // every address, extended and data lane carries its own pattern, so a leak from a wrong lane shows at once
  always_comb begin
    for (int c = 0; c < `DBM_NCH; c++) begin
      addr_out[c] = {c[2:0], 9'h0a5};
      ext_out[c] = ~c[2:0];
      data_out[c] = {9'h13c, c[2:0]};
      cyc_out[c] = c[0];
      dir_out[c] = c[1];
      inh_out[c] = c[2];
    end
  end
endmodule

// ### dv/tb_data_break_channel_multiplexer.sv
`timescale 1ns/10ps
`include "dbm_defs.svh"

module tb_data_break_channel_multiplexer;
  typedef struct packed {
    logic [6:0] want;
    logic [2:0] ch;
  } dbm_row_s;

  logic core_clk, nrst, pwr, tpls, acc, wcov, done, brk_n, cy_o, dr_o, ih_o, lv, lr;
  logic [11:0] ma_o, dat_o;
  logic [2:0] ex_o;
  logic [6:0] want, req, cy, dr, ih, acc_o, wc_o, act, dsel, asel;
  logic [6:0][11:0] dev_a, dev_d;
  logic [6:0][2:0] dev_x;
  logic [29:0] ld;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  dbm_row_s rows [8] = '{'{7'h01, 3'd0}, '{7'h40, 3'd6}, '{7'h60, 3'd5}, '{7'h00, 3'd6},
    '{7'h0c, 3'd2}, '{7'h00, 3'd3}, '{7'h12, 3'd1}, '{7'h00, 3'd4}};

  dbm_mux dut (.core_clk_in(core_clk), .nrst_in(nrst), .power_clear_in(pwr),
    .first_timing_pulse_in(tpls), .address_accepted_pulse_in(acc),
    .word_count_overflow_in(wcov), .break_done_in(done), .break_request_n_out(brk_n),
    .memory_address_bits_out(ma_o), .extended_address_bits_out(ex_o),
    .cycle_type_select_out(cy_o), .data_in_dir_out(dr_o), .transfer_data_bits_out(dat_o),
    .current_address_increment_inhibit_out(ih_o), .break_request_line_in(req),
    .memory_address_bits_dev_in(dev_a), .extended_address_bits_dev_in(dev_x),
    .cycle_type_select_dev_in(cy), .data_out_dir_dev_in(dr),
    .transfer_data_bits_dev_in(dev_d), .current_address_increment_inhibit_dev_in(ih),
    .address_accepted_pulse_out(acc_o), .word_count_overflow_dev_out(wc_o),
    .channel_active_level_out(act), .data_bits_select_out(dsel),
    .address_lines_select_out(asel), .log_valid_out(lv), .log_ready_in(lr),
    .log_data_out(ld));

  dbm_periph_model peri (.core_clk_in(core_clk), .nrst_in(nrst), .want_in(want),
    .accept_in(acc_o), .req_out(req), .addr_out(dev_a), .ext_out(dev_x), .cyc_out(cy),
    .dir_out(dr), .data_out(dev_d), .inh_out(ih));

  function automatic logic [11:0] ea(input logic [2:0] c);
    return {c, 9'h0a5};
  endfunction

  function automatic logic [11:0] ed(input logic [2:0] c);
    return {9'h13c, c};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one full break: wish, timing pulse, accept, overflow, done
  task automatic brk(input logic [6:0] w, input logic [2:0] c);
    logic [6:0] oh;
    oh = 7'h01 << c;
    @(posedge core_clk) want <= w;
    @(posedge core_clk) want <= 7'h00;
    tpls <= 1'b1;
    @(posedge core_clk) tpls <= 1'b0;
    #1 chk("select", oh, asel);
    chk("brk_n", 0, brk_n);
    @(posedge core_clk) acc <= 1'b1;
    #1 chk("addr", ea(c), ma_o);
    chk("ext", {29'h0, ~c}, ex_o);
    chk("cyc", c[0], cy_o);
    chk("dir", c[1], dr_o);
    chk("acc_out", oh, acc_o);
    @(posedge core_clk) acc <= 1'b0;
    wcov <= 1'b1;
    #1 chk("grant", oh, dsel);
    chk("active", oh, act);
    chk("wcov_out", oh, wc_o);
    @(posedge core_clk) wcov <= 1'b0;
    done <= 1'b1;
    #1 chk("data", ed(c), dat_o);
    chk("inh", c[2], ih_o);
    @(posedge core_clk) done <= 1'b0;
    #1 chk("rel_sel", 0, asel);
    chk("rel_grant", 0, dsel);
    chk("rel_active", 0, act);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {nrst, pwr, tpls, acc, wcov, done, want} = '0;
    lr = 1'b1;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk("rst_sel", 0, asel);
    chk("rst_grant", 0, dsel);
    chk("rst_brk_n", 1, brk_n);
    chk("rst_log", 0, lv);
    foreach (rows[i]) brk(rows[i].want, rows[i].ch);
    // timing pulse and overflow with nothing pending or granted
    @(posedge core_clk) tpls <= 1'b1;
    wcov <= 1'b1;
    #1 chk("idle_wcov", 0, wc_o);
    @(posedge core_clk) tpls <= 1'b0;
    wcov <= 1'b0;
    #1 chk("idle_sel", 0, asel);
    // power clear while a grant stands
    @(posedge core_clk) want <= 7'h10;
    @(posedge core_clk) want <= 7'h00;
    tpls <= 1'b1;
    @(posedge core_clk) tpls <= 1'b0;
    @(posedge core_clk) acc <= 1'b1;
    @(posedge core_clk) acc <= 1'b0;
    pwr <= 1'b1;
    @(posedge core_clk) pwr <= 1'b0;
    #1 chk("pc_sel", 0, asel);
    chk("pc_grant", 0, dsel);
    chk("pc_active", 0, act);
    // stalled sink: fill the log until arbitration is refused
    @(posedge core_clk) lr <= 1'b0;
    repeat (32) brk(7'h08, 3'd3);
    repeat (4) @(posedge core_clk);
    @(posedge core_clk) want <= 7'h08;
    @(posedge core_clk) want <= 7'h00;
    tpls <= 1'b1;
    @(posedge core_clk) tpls <= 1'b0;
    #1 chk("full_sel", 0, asel);
    @(posedge core_clk) lr <= 1'b1;
    n = 0;
    repeat (100) begin
      @(negedge core_clk);
      if (lv === 1'b1) begin
        if (n == 0) chk("log_rec", {3'd3, ea(3'd3), 3'd4, ed(3'd3)}, ld);
        n++;
      end
    end
    chk("log_count", 32, n);
    // the refused request is still pending and is served now
    brk(7'h00, 3'd3);
    report_and_stop();
  end
endmodule
